/* design/pcpr_pkg.sv */
// Constants and carrier types for the peripheral clock prescale and reset block.
// Assumes a single bus clock domain and a plain register port driven by one master.
package pcpr_pkg;

    // Register map, byte offsets on an 8-bit address.
    localparam logic [7:0] PRESCALE0_OFS = 8'h04;
    localparam logic [7:0] PRESCALE1_OFS = 8'h08;
    localparam logic [7:0] CLKOUT_PRE_OFS = 8'h0c;
    localparam logic [7:0] SOFT_RESET_OFS = 8'h10;
    localparam logic [7:0] CLKOUT_SEL_OFS = 8'h14;

    // Writable bits of each register; every other bit reads as zero.
    localparam logic [31:0] PRESCALE0_MASK = 32'h77777777;
    localparam logic [31:0] PRESCALE1_MASK = 32'h77737777;
    localparam logic [31:0] CLKOUT_PRE_MASK = 32'h0000000f;
    localparam logic [31:0] SOFT_RESET_MASK = 32'h03f3bfef;
    localparam logic [31:0] CLKOUT_SEL_MASK = 32'h00000007;
    localparam logic [31:0] REG_RESET_VAL = 32'h00000000;

    // Prescaler field geometry: eight 4-bit slots per register, 3 bits used (2 in the tick divider's slot).
    localparam int FIELD_PITCH = 4;
    localparam int FIELDS_PER_REG = 8;
    localparam int NUM_DIV = 16;
    localparam int DIV_CNT_W = 5;
    localparam int OUT_CNT_W = 9;

    // Encoding families of the prescaler fields.
    localparam logic [1:0] KIND_STD = 2'h0;
    localparam logic [1:0] KIND_WDOG = 2'h1;
    localparam logic [1:0] KIND_TICK = 2'h2;
    localparam logic [1:0] KIND_AUDIO = 2'h3;

    // Codes with special meaning.
    localparam logic [2:0] CODE_MAX_STD = 3'h4;
    localparam logic [2:0] CODE_WDOG_32 = 3'h5;
    localparam logic [2:0] CODE_AUDIO_3 = 3'h7;
    localparam logic [4:0] TERM_DIV3 = 5'h02;
    localparam logic [3:0] CLKOUT_CODE_MAX = 4'h9;

    // Divider index i uses register i/8, field at bit 4*(i%8).
    localparam logic [NUM_DIV-1:0][1:0] DIV_KIND = {
        KIND_STD, KIND_STD, KIND_WDOG, KIND_TICK,
        KIND_AUDIO, KIND_STD, KIND_STD, KIND_STD,
        KIND_STD, KIND_STD, KIND_STD, KIND_STD,
        KIND_STD, KIND_STD, KIND_STD, KIND_STD};

    // Soft reset bits; bit 31 never pulses, so the tick divider has no reset.
    localparam logic [NUM_DIV-1:0][4:0] DIV_RST_BIT = {
        5'd7, 5'd20, 5'd24, 5'd31, 5'd22, 5'd21, 5'd17, 5'd16,
        5'd10, 5'd13, 5'd12, 5'd11, 5'd9, 5'd8, 5'd6, 5'd5};

    // Clock output source select codes.
    localparam logic [2:0] SRC_OFF = 3'h0;
    localparam logic [2:0] SRC_LOW_INT = 3'h1;
    localparam logic [2:0] SRC_LOW_EXT = 3'h2;
    localparam logic [2:0] SRC_BUS = 3'h4;
    localparam logic [2:0] SRC_HIGH_INT = 3'h5;
    localparam logic [2:0] SRC_HIGH_EXT = 3'h6;

    localparam int RST_W = 26;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wrData;
        logic wr;
        logic rd;
    } pcpr_bus_req_type;

    typedef struct packed {
        logic lowIntOsc;
        logic lowExtXtal;
        logic highIntOsc;
        logic highExtXtal;
    } pcpr_osc_in_type;

    typedef struct packed {
        logic [NUM_DIV-1:0] periphTick;
        logic clkOutTick;
        logic clkOutActive;
    } pcpr_clk_out_type;

endpackage

/* design/pcpr_top.sv */
// Peripheral clock prescaler, clock output divider and self-clearing soft resets.
// Assumes one bus clock, a single register master and oscillator pins from other domains.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module pcpr_top (
    // Clock, reset and freeze.
    input wire logic clk,
    input wire logic rstn,
    input wire logic clkEn,
    // Register port.
    input wire pcpr_pkg::pcpr_bus_req_type busReq,
    output logic [31:0] regRdData,
    // Oscillator inputs from other clock domains.
    input wire pcpr_pkg::pcpr_osc_in_type oscIn,
    // Divided clock enables towards the peripherals.
    output pcpr_pkg::pcpr_clk_out_type clkOut,
    // Soft reset pulses towards the peripherals.
    output logic [pcpr_pkg::RST_W-1:0] softReset
);
    import pcpr_pkg::*;

    // Returns {valid, terminal count} for a prescale code of a given family.
    function automatic logic [DIV_CNT_W:0] divTerm(input logic [2:0] code,
                                                  input logic [1:0] kind);
        logic [DIV_CNT_W:0] res;
        res = '0;
        if (kind == KIND_TICK) begin
            res = {1'b1, 5'((5'h1 << code[1:0]) - 5'h1)};
        end else if (code <= CODE_MAX_STD) begin
            res = {1'b1, 5'((5'h1 << code) - 5'h1)};
        end else if (kind == KIND_WDOG && code == CODE_WDOG_32) begin
            res = {1'b1, 5'h1f};
        end else if (kind == KIND_AUDIO && code == CODE_AUDIO_3) begin
            res = {1'b1, TERM_DIV3};
        end
        return res;
    endfunction

    // Reset release through two flip-flops.
    logic rstMeta_ff;
    logic rstSync_ff;
    wire logic rstSyncN = rstSync_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta_ff <= 1'b0;
            rstSync_ff <= 1'b0;
        end else if (clkEn) begin
            rstMeta_ff <= 1'b1;
            rstSync_ff <= rstMeta_ff;
        end
    end

    // Address decode.
    wire logic hitPre0 = busReq.addr == PRESCALE0_OFS;
    wire logic hitPre1 = busReq.addr == PRESCALE1_OFS;
    wire logic hitOutPre = busReq.addr == CLKOUT_PRE_OFS;
    wire logic hitRst = busReq.addr == SOFT_RESET_OFS;
    wire logic hitSel = busReq.addr == CLKOUT_SEL_OFS;

    // Registers.
    logic [31:0] pre0_ff;
    logic [31:0] pre1_ff;
    logic [31:0] outPre_ff;
    logic [31:0] outSel_ff;
    logic [31:0] rst_ff;
    logic [31:0] rdData_ff;

    // Reserved bits are masked on the way in, so they hold zero for ever.
    wire logic [31:0] nxt_pre0 = (busReq.wr && hitPre0) ?
        (busReq.wrData & PRESCALE0_MASK) : pre0_ff;
    wire logic [31:0] nxt_pre1 = (busReq.wr && hitPre1) ?
        (busReq.wrData & PRESCALE1_MASK) : pre1_ff;
    wire logic [31:0] nxt_outPre = (busReq.wr && hitOutPre) ?
        (busReq.wrData & CLKOUT_PRE_MASK) : outPre_ff;
    wire logic [31:0] nxt_outSel = (busReq.wr && hitSel) ?
        (busReq.wrData & CLKOUT_SEL_MASK) : outSel_ff;
    // Ones written stand for exactly one cycle, zeros written do nothing.
    wire logic [31:0] nxt_rst = (busReq.wr && hitRst) ?
        (busReq.wrData & SOFT_RESET_MASK) : 32'h00000000;

    wire logic [31:0] rdMux =
        hitPre0 ? pre0_ff :
        hitPre1 ? pre1_ff :
        hitOutPre ? outPre_ff :
        hitRst ? rst_ff :
        hitSel ? outSel_ff : 32'h00000000;
    wire logic [31:0] nxt_rdData = busReq.rd ? rdMux : 32'h00000000;

    // One short block per register keeps each reset value beside its freeze.
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pre0_ff <= REG_RESET_VAL;
        end else if (clkEn) begin
            pre0_ff <= nxt_pre0;
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pre1_ff <= REG_RESET_VAL;
        end else if (clkEn) begin
            pre1_ff <= nxt_pre1;
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            outPre_ff <= REG_RESET_VAL;
        end else if (clkEn) begin
            outPre_ff <= nxt_outPre;
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            outSel_ff <= REG_RESET_VAL;
        end else if (clkEn) begin
            outSel_ff <= nxt_outSel;
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rst_ff <= REG_RESET_VAL;
        end else if (clkEn) begin
            rst_ff <= nxt_rst;
        end
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            rdData_ff <= REG_RESET_VAL;
        end else if (clkEn) begin
            rdData_ff <= nxt_rdData;
        end
    end

    assign regRdData = rdData_ff;
    assign softReset = rst_ff[RST_W-1:0];

    // Peripheral dividers. Each pulse is a bus-clock enable, so odd ratios cannot glitch.
    wire logic [NUM_DIV-1:0] tickVec;
    wire logic [63:0] preAll = {pre1_ff, pre0_ff};

    for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
        logic [DIV_CNT_W-1:0] cnt_ff;
        logic tick_ff;
        wire logic [2:0] code = preAll[i*FIELD_PITCH +: 3];
        wire logic [DIV_CNT_W:0] termInfo = divTerm(code, DIV_KIND[i]);
        wire logic [DIV_CNT_W-1:0] term = termInfo[DIV_CNT_W-1:0];
        wire logic valid = termInfo[DIV_CNT_W];
        // A soft reset realigns the divider, which is why it follows a ratio change.
        wire logic restart = rst_ff[DIV_RST_BIT[i]];
        wire logic atTerm = cnt_ff >= term;
        wire logic [DIV_CNT_W-1:0] nxt_cnt =
            (!valid || restart || atTerm) ? '0 : DIV_CNT_W'(cnt_ff + 1'b1);
        wire logic nxt_tick = valid && !restart && atTerm;
        assign tickVec[i] = tick_ff;

        always_ff @(posedge clk or negedge rstSyncN) begin
            if (!rstSyncN) begin
                cnt_ff <= '0;
                tick_ff <= 1'b0;
            end else if (clkEn) begin
                cnt_ff <= nxt_cnt;
                tick_ff <= nxt_tick;
            end
        end
    end

    // Oscillator pins: three flops, a change counts once the second and third agree.
    // Sampling at the bus clock only follows sources well below half its rate.
    logic [3:0] oscS1_ff;
    logic [3:0] oscS2_ff;
    logic [3:0] oscS3_ff;
    logic [3:0] oscLvl_ff;
    wire logic [3:0] oscRaw = {oscIn.highExtXtal, oscIn.highIntOsc,
                               oscIn.lowExtXtal, oscIn.lowIntOsc};
    wire logic [3:0] oscAgree = ~(oscS2_ff ^ oscS3_ff);
    wire logic [3:0] nxt_oscLvl = (oscAgree & oscS3_ff) | (~oscAgree & oscLvl_ff);
    wire logic [3:0] oscRise = nxt_oscLvl & ~oscLvl_ff;

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            oscS1_ff <= 4'h0;
            oscS2_ff <= 4'h0;
            oscS3_ff <= 4'h0;
            oscLvl_ff <= 4'h0;
        end else if (clkEn) begin
            oscS1_ff <= oscRaw;
            oscS2_ff <= oscS1_ff;
            oscS3_ff <= oscS2_ff;
            oscLvl_ff <= nxt_oscLvl;
        end
    end

    // Clock output source select and divider.
    wire logic [2:0] srcSel = outSel_ff[2:0];
    wire logic [3:0] outCode = outPre_ff[3:0];
    logic srcEdge;
    always_comb begin
        unique case (srcSel)
            SRC_LOW_INT: srcEdge = oscRise[0];
            SRC_LOW_EXT: srcEdge = oscRise[1];
            SRC_BUS: srcEdge = 1'b1;
            SRC_HIGH_INT: srcEdge = oscRise[2];
            SRC_HIGH_EXT: srcEdge = oscRise[3];
            default: srcEdge = 1'b0;
        endcase
    end

    logic [OUT_CNT_W-1:0] outCnt_ff;
    logic outTick_ff;
    logic outActive_ff;
    wire logic outValid = outCode <= CLKOUT_CODE_MAX;
    wire logic [OUT_CNT_W-1:0] outTerm =
        OUT_CNT_W'((10'h001 << outCode) - 10'h001);
    wire logic outActive = outValid && (srcSel != SRC_OFF);
    wire logic outAtTerm = outCnt_ff >= outTerm;
    wire logic [OUT_CNT_W-1:0] nxt_outCnt =
        !outActive ? '0 :
        !srcEdge ? outCnt_ff :
        outAtTerm ? '0 : OUT_CNT_W'(outCnt_ff + 1'b1);
    wire logic nxt_outTick = outActive && srcEdge && outAtTerm;

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            outCnt_ff <= '0;
            outTick_ff <= 1'b0;
            outActive_ff <= 1'b0;
        end else if (clkEn) begin
            outCnt_ff <= nxt_outCnt;
            outTick_ff <= nxt_outTick;
            outActive_ff <= outActive;
        end
    end

    assign clkOut.periphTick = tickVec;
    assign clkOut.clkOutTick = outTick_ff;
    assign clkOut.clkOutActive = outActive_ff;

endmodule // pcpr_top

`default_nettype wire

/* testbench/pcpr_top_asserts.sv */
// Concurrent checks on the ports of the prescale and soft reset block.
// Assumes one bus clock and a master that never raises read and write together.
`timescale 1ns/1ns
`default_nettype none

module pcpr_top_asserts (
    // Clock, reset and freeze.
    input wire logic clk,
    input wire logic rstn,
    input wire logic clkEn,
    // Register port.
    input wire pcpr_pkg::pcpr_bus_req_type busReq,
    input wire logic [31:0] regRdData,
    // Oscillator inputs.
    input wire pcpr_pkg::pcpr_osc_in_type oscIn,
    // Outputs towards the peripherals.
    input wire pcpr_pkg::pcpr_clk_out_type clkOut,
    input wire logic [pcpr_pkg::RST_W-1:0] softReset
);
    import pcpr_pkg::*;
    // Shadow of the first prescale register, so field codes can be judged at the ports.
    logic [31:0] pre0_ff;
    logic [31:0] nxt_pre0;
    logic wrPre0;
    logic wrRst;
    logic mapped;
    logic [25:0] rstData;
    assign wrPre0 = clkEn && busReq.wr && busReq.addr == PRESCALE0_OFS;
    assign wrRst = clkEn && busReq.wr && busReq.addr == SOFT_RESET_OFS;
    assign nxt_pre0 = wrPre0 ? (busReq.wrData & PRESCALE0_MASK) : pre0_ff;
    assign rstData = busReq.wrData[25:0] & 26'h3f3bfef;
    assign mapped = busReq.addr inside {PRESCALE0_OFS, PRESCALE1_OFS, CLKOUT_PRE_OFS,
        SOFT_RESET_OFS, CLKOUT_SEL_OFS};
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre0_ff <= REG_RESET_VAL;
        end else begin
            pre0_ff <= nxt_pre0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_read_idle: assert property ($past(clkEn) && !$past(busReq.rd) |-> regRdData == 32'h0)
        else $error("read data not idle");
    chk_rst_clears: assert property (|softReset && clkEn && !wrRst |=> softReset == '0)
        else $error("soft reset held too long");
    chk_rst_cause: assert property (|softReset |-> $past(busReq.wr) && $past(busReq.addr) == SOFT_RESET_OFS)
        else $error("soft reset without a write");
    chk_rst_map: assert property (wrRst |=> softReset == $past(rstData))
        else $error("soft reset bits wrong");
    chk_pre_read: assert property (clkEn && busReq.rd && busReq.addr == PRESCALE0_OFS |=> regRdData == pre0_ff)
        else $error("prescale read back wrong");
    chk_unmapped_read: assert property (clkEn && busReq.rd && !mapped |=> regRdData == 32'h0)
        else $error("unmapped read not zero");
    chk_reserved_stop: assert property (pre0_ff[2:0] > CODE_MAX_STD && $past(pre0_ff[2:0]) > CODE_MAX_STD |-> !clkOut.periphTick[0])
        else $error("reserved code still ticks");
    chk_div_two: assert property (pre0_ff[2:0] == 3'h1 && $stable(pre0_ff) && clkOut.periphTick[0] |=> !clkOut.periphTick[0])
        else $error("divide by two ticked twice");
    chk_out_quiet: assert property (!clkOut.clkOutActive ##1 !clkOut.clkOutActive |-> !clkOut.clkOutTick)
        else $error("clock output ticks while off");
endmodule // pcpr_top_asserts

bind pcpr_top pcpr_top_asserts u_asserts (.clk, .rstn, .clkEn, .busReq, .regRdData, .oscIn,
    .clkOut, .softReset);

`default_nettype wire

/* testbench/pcpr_periph_model.sv */
// Peripheral side: measures the spacing of every clock enable it receives.
// Assumes enables are one-cycle pulses on the bus clock.
`timescale 1ns/1ns
`default_nettype none

module pcpr_periph_model (
    // Bus clock.
    input wire logic clk,
    // Enables of the sixteen peripherals and the clock output.
    input wire logic [16:0] tick,
    // Cycles between the last two enables of each.
    output var int period [0:16]
);
    int cyc = 0;
    int last [0:16];
    // Only the latest gap is kept, so a wait must span two enables at the slowest rate.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 17; i++) begin
            if (tick[i] === 1'b1) begin
                period[i] <= cyc - last[i];
                last[i] <= cyc;
            end
        end
    end
endmodule // pcpr_periph_model

`default_nettype wire

/* testbench/pcpr_top_bench.sv */
// Self-checking bench: register port tasks, divider periods and soft reset pulses.
// Assumes the checker is bound to the block and the peripheral model measures periods.
`timescale 1ns/1ns
`default_nettype none

module pcpr_top_bench;
    import pcpr_pkg::*;
    logic clk = 1'b0;
    logic rstn;
    logic clkEn;
    pcpr_bus_req_type busReq;
    logic [31:0] regRdData;
    pcpr_osc_in_type oscIn = '0;
    int oscCyc = 0;
    pcpr_clk_out_type clkOut;
    logic [RST_W-1:0] softReset;
    int period [0:16];
    int num_errors = 0;
    int checked = 0;
    logic [31:0] rdVal;
    logic [7:0] offs [0:5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [31:0] masks [0:5] = '{32'h77777777, 32'h77737777, 32'h0000000f, 32'h0, 32'h7, 32'h0};
    logic [2:0] srcCodes [0:2] = '{3'h2, 3'h5, 3'h6};
    int srcPeriods [0:2] = '{24, 28, 32};
    int expDiv [0:16] = '{2, 1, 4, 8, 1, 16, 16, 16, 1, 2, 4, 3, 8, 32, 2, 16, 8};

    pcpr_top u_dut (.clk, .rstn, .clkEn, .busReq, .regRdData, .oscIn, .clkOut, .softReset);
    pcpr_periph_model u_model (.clk, .tick({clkOut.clkOutTick, clkOut.periphTick}), .period);

    always #10 clk = ~clk;
    // Slow oscillators with periods of 20, 24, 28 and 32 cycles, so a wrong source shows.
    always @(posedge clk) begin
        oscCyc <= oscCyc + 1;
        for (int k = 0; k < 4; k++) begin
            if (oscCyc % (10 + 2 * k) == 9 + 2 * k) begin
                oscIn[3 - k] <= ~oscIn[3 - k];
            end
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        busReq <= '{addr: a, wrData: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1 rdVal = regRdData;
        check(rdVal, e);
    endtask
    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        $display("unexpected at %0t: run hung", $time);
        close_out();
    end

    initial begin
        rstn = 1'b0;
        clkEn = 1'b1;
        busReq = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            rdchk(offs[i], 32'h0);
            wr(offs[i], 32'hffffffff);
            rdchk(offs[i], masks[i]);
        end
        $display("register test done");
        wr(SOFT_RESET_OFS, 32'hffffffff);
        #1 check({6'h0, softReset}, 32'h03f3bfef);
        @(posedge clk);
        #1 check({6'h0, softReset}, 32'h0);
        wr(SOFT_RESET_OFS, 32'h0);
        #1 check({6'h0, softReset}, 32'h0);
        $display("soft reset test done");
        wr(PRESCALE0_OFS, 32'h44403201);
        wr(PRESCALE1_OFS, 32'h41537210);
        wr(CLKOUT_SEL_OFS, 32'h4);
        wr(CLKOUT_PRE_OFS, 32'h3);
        wr(SOFT_RESET_OFS, 32'h03f3bfef);
        repeat (80) @(posedge clk);
        for (int i = 0; i < 17; i++) begin
            check(period[i], expDiv[i]);
        end
        check({31'h0, clkOut.clkOutActive}, 32'h1);
        $display("divider test done");
        wr(CLKOUT_SEL_OFS, 32'h1);
        wr(CLKOUT_PRE_OFS, 32'h1);
        repeat (130) @(posedge clk);
        check(period[16], 40);
        wr(CLKOUT_PRE_OFS, 32'h0);
        for (int s = 0; s < 3; s++) begin
            wr(CLKOUT_SEL_OFS, {29'h0, srcCodes[s]});
            repeat (90) @(posedge clk);
            check(period[16], srcPeriods[s]);
        end
        wr(CLKOUT_PRE_OFS, 32'ha);
        repeat (2) @(posedge clk);
        #1 check({31'h0, clkOut.clkOutActive}, 32'h0);
        wr(PRESCALE0_OFS, 32'h5);
        repeat (10) @(posedge clk);
        rdchk(PRESCALE0_OFS, 32'h5);
        $display("clock output and reserved code test done");
        clkEn <= 1'b0;
        wr(PRESCALE0_OFS, 32'h3);
        clkEn <= 1'b1;
        rdchk(PRESCALE0_OFS, 32'h5);
        $display("freeze test done");
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(PRESCALE0_OFS, 32'h0);
        rdchk(PRESCALE1_OFS, 32'h0);
        $display("reset test done");
        close_out();
    end
endmodule // pcpr_top_bench

`default_nettype wire
